// ===== servo_common_input_sequencer.sv
// Function
// RULE1: While servo enable is asserted, enter servo-on and energise the motor.
// RULE2: Ignore servo enable until about 2 s after power-on.
// RULE3: Host waits at least 100 ms after servo-on before motion commands.
// RULE4: Releasing servo enable enters servo-off and cuts motor current.
// RULE5: Servo-off setting chooses dynamic brake and deviation counter clearing.
// RULE6: Host should not toggle servo enable to start and stop the motor.
// RULE7: Alarm clears only after alarm clear held continuously 120 ms or more.
// RULE8: Some alarm types stay latched whatever the alarm clear input does.
// RULE9: Control mode selects what the shared pin does.
// RULE10: Position mode clears deviation counter after shared pin held 2 ms.
// RULE11: Internal velocity mode uses shared pin as speed-select bit 2.
// RULE12: Inputs synchronised; hold times counted on consecutive samples, restarting on release.
`timescale 1ns/1ps
`default_nettype none
module servo_common_input_sequencer
    import servo_seq_pkg::*;
#(
    parameter int unsigned LOCKOUT_CYC = servo_seq_pkg::POWER_ON_LOCKOUT_CYC,
    parameter int unsigned SETTLE_CYC = servo_seq_pkg::MOTION_SETTLE_CYC,
    parameter int unsigned ALARM_HOLD_CYC = servo_seq_pkg::ALARM_CLEAR_HOLD_CYC,
    parameter int unsigned DEV_HOLD_CYC = servo_seq_pkg::DEV_CLEAR_HOLD_CYC
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Pins, high when shorted to the input common
    input wire logic servo_enable_in_i,
    input wire logic alarm_clear_in_i,
    input wire logic shared_pin_i,
    input wire logic speed_select_bit1_i,
    // Configuration from the rest of the drive
    input wire servo_seq_pkg::ctrl_mode_t ctrl_mode_i,
    input wire logic [servo_seq_pkg::OFFSEQ_W-1:0] servo_off_sequence_setting_i,
    // Alarm events from protection logic
    input wire logic alarm_set_i,
    input wire logic alarm_sticky_i,
    // Results
    output logic servo_on_o,
    output logic motor_energize_o,
    output logic dynamic_brake_o,
    output logic dev_clear_o,
    output logic motion_ready_o,
    output logic alarm_o,
    output logic [1:0] speed_select_o
);
    import servo_seq_pkg::*;

    logic en_level;
    logic ac_held;
    logic ac_level;
    logic sp_level;
    logic sp_held;
    logic sb1_level;

    // Enable and bit 1 need only the qualified level
    input_qualifier #(
        .HOLD_CYC(1),
        .CNT_W(CNT_W)
    ) u_en (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .pin_i(servo_enable_in_i),
        .level_o(en_level),
        .held_o()
    );

    // Alarm clear must be held for the full clear time
    input_qualifier #(
        .HOLD_CYC(ALARM_HOLD_CYC),
        .CNT_W(CNT_W)
    ) u_ac (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .pin_i(alarm_clear_in_i),
        .level_o(ac_level),
        .held_o(ac_held)
    );

    // Shared pin: hold time matters only in position mode
    input_qualifier #(
        .HOLD_CYC(DEV_HOLD_CYC),
        .CNT_W(CNT_W)
    ) u_sp (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .pin_i(shared_pin_i),
        .level_o(sp_level),
        .held_o(sp_held)
    );

    input_qualifier #(
        .HOLD_CYC(1),
        .CNT_W(CNT_W)
    ) u_sb1 (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .pin_i(speed_select_bit1_i),
        .level_o(sb1_level),
        .held_o()
    );

    servo_state_t state_q;
    servo_state_t state_d;
    logic [CNT_W-1:0] lock_cnt_q;
    logic [CNT_W-1:0] settle_cnt_q;
    logic alarm_q;
    logic sticky_q;
    logic ac_held_q;
    logic servo_on_q;
    logic energize_q;
    logic brake_q;
    logic dev_clear_q;
    logic ready_q;
    logic [1:0] speed_q;

    wire lock_done = (lock_cnt_q >= CNT_W'(LOCKOUT_CYC));
    wire settle_done = (settle_cnt_q >= CNT_W'(SETTLE_CYC));
    wire pos_mode = (ctrl_mode_i == MODE_POSITION); // see RULE9
    wire vel_mode = (ctrl_mode_i == MODE_INT_VELOCITY); // see RULE9
    wire off_db = servo_off_sequence_setting_i[OFFSEQ_DB_BIT];
    wire off_clr = servo_off_sequence_setting_i[OFFSEQ_CLR_BIT];
    wire is_on = (state_q == SERVO_ENABLE_IN);
    // Clear fires once per hold, on the edge where the hold completes
    wire ac_fire = ac_held && !ac_held_q; // see RULE7
    // New alarm wins over a clear in the same cycle; sticky alarms never clear
    wire alarm_d = alarm_set_i || (alarm_q && !(ac_fire && !sticky_q)); // see RULE8
    wire sticky_d = (alarm_set_i && alarm_sticky_i) || (sticky_q && alarm_q); // see RULE8
    wire dev_clear_d = (pos_mode && sp_held) || (!is_on && off_clr); // see RULE10
    wire [1:0] speed_d = vel_mode ? {sp_level, sb1_level} : {1'b0, sb1_level}; // see RULE11

    // Saturating step shared by the lockout and settle timers
    function automatic logic [CNT_W-1:0] sat_inc(
        input logic [CNT_W-1:0] cnt,
        input logic done
    );
        sat_inc = done ? cnt : cnt + CNT_W'(1);
    endfunction : sat_inc

    logic [CNT_W-1:0] lock_cnt_d;
    logic [CNT_W-1:0] settle_cnt_d;
    // Lockout restarts on every reset release, not only at power-on
    assign lock_cnt_d = sat_inc(lock_cnt_q, lock_done); // see RULE2
    // Host must hold off motion until this counter runs out
    assign settle_cnt_d = is_on ? sat_inc(settle_cnt_q, settle_done) : '0; // see RULE3

    // On, energise and brake follow the next state, so they switch with the state register; ready follows the present state
    wire servo_on_d = (state_d == SERVO_ENABLE_IN);
    wire brake_d = !servo_on_d && off_db;
    wire ready_d = is_on && settle_done;

    always_comb begin
        case (state_q)
            SRV_LOCKOUT: state_d = lock_done ? SRV_OFF : SRV_LOCKOUT; // see RULE2
            SRV_OFF: state_d = (en_level && !alarm_q) ? SERVO_ENABLE_IN : SRV_OFF; // see RULE1
            SERVO_ENABLE_IN: state_d = (en_level && !alarm_q) ? SERVO_ENABLE_IN : SRV_OFF; // see RULE4
            default: state_d = SRV_LOCKOUT;
        endcase
    end

    // Sequence state and its two timers
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            state_q <= SRV_LOCKOUT;
            lock_cnt_q <= '0;
            settle_cnt_q <= '0;
        end else begin
            state_q <= state_d;
            lock_cnt_q <= lock_cnt_d; // see RULE2
            settle_cnt_q <= settle_cnt_d;
        end
    end

    // Alarm latch
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            alarm_q <= 1'b0;
            sticky_q <= 1'b0;
            ac_held_q <= 1'b0;
        end else begin
            alarm_q <= alarm_d; // see RULE7
            sticky_q <= sticky_d; // see RULE8
            ac_held_q <= ac_held;
        end
    end

    // Power stage outputs
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            servo_on_q <= 1'b0;
            energize_q <= 1'b0;
            brake_q <= 1'b0;
        end else begin
            servo_on_q <= servo_on_d; // see RULE1
            energize_q <= servo_on_d; // see RULE4
            brake_q <= brake_d; // see RULE5
        end
    end

    // Position and speed outputs
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            dev_clear_q <= 1'b0;
            ready_q <= 1'b0;
            speed_q <= 2'h0;
        end else begin
            dev_clear_q <= dev_clear_d; // see RULE5
            ready_q <= ready_d;
            speed_q <= speed_d; // see RULE11
        end
    end

    assign servo_on_o = servo_on_q;
    assign motor_energize_o = energize_q;
    assign dynamic_brake_o = brake_q;
    assign dev_clear_o = dev_clear_q;
    assign motion_ready_o = ready_q;
    assign alarm_o = alarm_q;
    assign speed_select_o = speed_q;
endmodule : servo_common_input_sequencer
`default_nettype wire

// ===== servo_seq_pkg.sv
package servo_seq_pkg;
    // Clock rate
    localparam int unsigned CLK_HZ = 200_000_000;
    // Documented times
    localparam int unsigned POWER_ON_LOCKOUT_MS = 2000;
    localparam int unsigned MOTION_SETTLE_MS = 100;
    localparam int unsigned ALARM_CLEAR_HOLD_MS = 120;
    localparam int unsigned DEV_CLEAR_HOLD_MS = 2;
    // Derived cycle counts (least times; per-ms count rounds down)
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned POWER_ON_LOCKOUT_CYC = POWER_ON_LOCKOUT_MS * CYC_PER_MS;
    localparam int unsigned MOTION_SETTLE_CYC = MOTION_SETTLE_MS * CYC_PER_MS;
    localparam int unsigned ALARM_CLEAR_HOLD_CYC = ALARM_CLEAR_HOLD_MS * CYC_PER_MS;
    localparam int unsigned DEV_CLEAR_HOLD_CYC = DEV_CLEAR_HOLD_MS * CYC_PER_MS;
    // Counter width covering the longest count
    localparam int unsigned CNT_W = 32;
    // Servo-off sequence setting field positions
    localparam int unsigned OFFSEQ_DB_BIT = 0;
    localparam int unsigned OFFSEQ_CLR_BIT = 1;
    localparam int unsigned OFFSEQ_W = 2;

    typedef enum logic [1:0] {
        MODE_POSITION = 2'b00,
        MODE_INT_VELOCITY = 2'b01,
        MODE_OTHER = 2'b10
    } ctrl_mode_t;

    typedef enum logic [1:0] {
        SRV_LOCKOUT = 2'b00,
        SRV_OFF = 2'b01,
        SERVO_ENABLE_IN = 2'b10
    } servo_state_t;
endpackage : servo_seq_pkg

// ===== input_qualifier.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage synchroniser plus consecutive-sample hold counter
module input_qualifier #(
    parameter int unsigned HOLD_CYC = 1,
    parameter int unsigned CNT_W = 32
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // Raw pin, active high
    input wire logic pin_i,
    // Qualified results
    output logic level_o,
    output logic held_o
);
    logic s1_q;
    logic s2_q;
    logic s3_q;
    logic level_q;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    wire agree = (s2_q == s3_q);
    wire level_d = agree ? s2_q : level_q;
    wire at_hold = (cnt_q >= CNT_W'(HOLD_CYC));

    // Count restarts whenever the level drops; saturates at the hold figure
    assign cnt_d = !level_q ? '0 : (at_hold ? cnt_q : cnt_q + CNT_W'(1)); // see RULE12

    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            level_q <= 1'b0;
            cnt_q <= '0;
        end else begin
            s1_q <= pin_i; // see RULE12
            s2_q <= s1_q;
            s3_q <= s2_q;
            level_q <= level_d;
            cnt_q <= cnt_d;
        end
    end

    assign level_o = level_q;
    assign held_o = level_q && at_hold;
endmodule : input_qualifier
`default_nettype wire

// ===== seq_checker.sv
`timescale 1ns/1ps
`default_nettype none
module seq_checker
    import servo_seq_pkg::*;
#(
    parameter int unsigned LOCKOUT_CYC = 50,
    parameter int unsigned ALARM_HOLD_CYC = 12,
    parameter int unsigned DEV_HOLD_CYC = 6
) (
    // Clock, reset and inputs (grouped to save space)
    input wire logic clk_i, srst_i, servo_enable_in_i, alarm_clear_in_i, shared_pin_i,
    input wire logic alarm_set_i, alarm_sticky_i,
    input wire servo_seq_pkg::ctrl_mode_t ctrl_mode_i,
    input wire logic [servo_seq_pkg::OFFSEQ_W-1:0] servo_off_sequence_setting_i,
    // Results
    input wire logic servo_on_o, motor_energize_o, dynamic_brake_o, dev_clear_o, alarm_o
);
    int unsigned lk_q, clr_q, sh_q;
    // Cycles since reset and raw-pin run lengths; sync latency only makes the design later
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            lk_q <= 0;
            clr_q <= 0;
            sh_q <= 0;
        end else begin
            lk_q <= (lk_q < LOCKOUT_CYC) ? lk_q + 1 : lk_q;
            clr_q <= alarm_clear_in_i ? clr_q + 1 : 0;
            sh_q <= shared_pin_i ? sh_q + 1 : 0;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (srst_i);
    lock_hold_a: assert property (lk_q < LOCKOUT_CYC |-> !servo_on_o)
        else $error("servo on in lockout");
    on_energize_a: assert property (servo_on_o |-> motor_energize_o)
        else $error("motor not energized");
    enable_on_a: assert property (
        (servo_enable_in_i && !alarm_o && lk_q >= LOCKOUT_CYC)[*8] |-> servo_on_o)
        else $error("servo on missing");
    release_off_a: assert property (!servo_enable_in_i[*8] |-> !servo_on_o && !motor_energize_o)
        else $error("servo off missing");
    brake_sel_a: assert property (
        !$past(srst_i) && !$past(servo_on_o) && !servo_on_o &&
        $stable(servo_off_sequence_setting_i)
        |-> dynamic_brake_o == servo_off_sequence_setting_i[OFFSEQ_DB_BIT])
        else $error("brake setting ignored");
    clear_hold_a: assert property ($fell(alarm_o) |-> clr_q >= ALARM_HOLD_CYC)
        else $error("alarm cleared early");
    sticky_keep_a: assert property (alarm_set_i && alarm_sticky_i |=> alarm_o[*8])
        else $error("sticky alarm released");
    dev_clear_a: assert property (
        servo_on_o && ctrl_mode_i == MODE_POSITION && sh_q > DEV_HOLD_CYC + 8 |-> dev_clear_o)
        else $error("deviation clear missing");
    cover property ($rose(servo_on_o));
    cover property ($fell(alarm_o));
    cover property ($rose(dev_clear_o));
endmodule : seq_checker
bind servo_common_input_sequencer seq_checker #(.LOCKOUT_CYC(LOCKOUT_CYC),
    .ALARM_HOLD_CYC(ALARM_HOLD_CYC), .DEV_HOLD_CYC(DEV_HOLD_CYC)) seq_checker_inst (.clk_i,
    .srst_i, .servo_enable_in_i, .alarm_clear_in_i, .shared_pin_i, .alarm_set_i,
    .alarm_sticky_i, .ctrl_mode_i, .servo_off_sequence_setting_i, .servo_on_o,
    .motor_energize_o, .dynamic_brake_o, .dev_clear_o, .alarm_o);
`default_nettype wire

// ===== host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // Clock and readiness
    input wire logic clk_i,
    input wire logic motion_ready_i,
    // Pins, high when shorted to the common
    output logic srv_o, clr_o, sh_o, b1_o,
    // Motion commands allowed
    output logic may_move_o
);
    assign may_move_o = motion_ready_i;
    initial {srv_o, clr_o, sh_o, b1_o} = 4'h0;
    // Pins {enable, clear, shared, bit1}; enable toggled only to test on and off
    task automatic drive(input logic [3:0] pins, input int n);
        @(posedge clk_i);
        #1 {srv_o, clr_o, sh_o, b1_o} = pins;
        repeat (n) @(posedge clk_i);
        #1;
    endtask : drive
endmodule : host_model
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import servo_seq_pkg::*;
    logic clk_i = 1'b0, srst_i = 1'b1, alarm_set_i = 1'b0, alarm_sticky_i = 1'b0;
    logic servo_enable_in_i, alarm_clear_in_i, shared_pin_i, speed_select_bit1_i;
    logic servo_on_o, motor_energize_o, dynamic_brake_o, dev_clear_o, motion_ready_o, alarm_o;
    logic [1:0] speed_select_o;
    logic [1:0] servo_off_sequence_setting_i = 2'h1;
    ctrl_mode_t ctrl_mode_i = MODE_POSITION;
    int n_mismatch = 0, cmp_count = 0;
    always #2.5 clk_i = ~clk_i;
    servo_common_input_sequencer #(.LOCKOUT_CYC(50), .SETTLE_CYC(20), .ALARM_HOLD_CYC(12),
        .DEV_HOLD_CYC(6)) servo_common_input_sequencer_inst (.clk_i, .srst_i,
        .servo_enable_in_i, .alarm_clear_in_i, .shared_pin_i, .speed_select_bit1_i,
        .ctrl_mode_i, .servo_off_sequence_setting_i, .alarm_set_i, .alarm_sticky_i,
        .servo_on_o, .motor_energize_o, .dynamic_brake_o, .dev_clear_o, .motion_ready_o,
        .alarm_o, .speed_select_o);
    host_model host_model_inst (.clk_i, .motion_ready_i(motion_ready_o),
        .srv_o(servo_enable_in_i), .clr_o(alarm_clear_in_i), .sh_o(shared_pin_i),
        .b1_o(speed_select_bit1_i), .may_move_o());
    task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : cyc
    task automatic t_on_off;
        host_model_inst.drive(4'h8, 40);
        chk({servo_on_o, dynamic_brake_o}, 4'h1);
        cyc(25);
        chk({servo_on_o, motor_energize_o, dynamic_brake_o}, 4'h6);
        servo_off_sequence_setting_i = 2'h3;
        host_model_inst.drive(4'h0, 10);
        chk({servo_on_o, motor_energize_o, dynamic_brake_o, dev_clear_o}, 4'h3);
        servo_off_sequence_setting_i = 2'h0;
        cyc(3);
        chk({dynamic_brake_o, dev_clear_o}, 4'h0);
        host_model_inst.drive(4'h8, 8);
        chk({servo_on_o, motion_ready_o}, 4'h2);
        cyc(25);
        chk(motion_ready_o, 4'h1);
        $display("on/off test done");
    endtask : t_on_off
    task automatic t_shared;
        repeat (3) begin
            host_model_inst.drive(4'hA, 3);
            host_model_inst.drive(4'h8, 2);
        end
        chk(dev_clear_o, 4'h0);
        host_model_inst.drive(4'hA, 18);
        chk(dev_clear_o, 4'h1);
        host_model_inst.drive(4'h8, 8);
        ctrl_mode_i = MODE_INT_VELOCITY;
        for (int v = 0; v < 4; v++) begin
            host_model_inst.drive({2'h2, v[1:0]}, 10);
            chk({dev_clear_o, speed_select_o}, {2'h0, v[1:0]});
        end
        ctrl_mode_i = MODE_OTHER;
        host_model_inst.drive(4'hB, 8);
        chk({dev_clear_o, speed_select_o}, 4'h1);
        host_model_inst.drive(4'h8, 8);
        ctrl_mode_i = MODE_POSITION;
        $display("shared pin test done");
    endtask : t_shared
    task automatic t_alarm(input logic sticky);
        alarm_set_i = 1'b1;
        alarm_sticky_i = sticky;
        cyc(1);
        alarm_set_i = 1'b0;
        cyc(8);
        chk({alarm_o, servo_on_o}, 4'h2);
        repeat (2) begin
            host_model_inst.drive(4'hC, 8);
            host_model_inst.drive(4'h8, 2);
        end
        chk(alarm_o, 4'h1);
        host_model_inst.drive(4'hC, 30);
        chk(alarm_o, {3'h0, sticky});
        host_model_inst.drive(4'h8, 2);
        $display("alarm test done");
    endtask : t_alarm
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        cyc(8);
        srst_i = 1'b0;
        t_on_off();
        t_shared();
        t_alarm(1'b0);
        t_alarm(1'b1);
        srst_i = 1'b1;
        cyc(3);
        srst_i = 1'b0;
        cyc(1);
        chk({alarm_o, servo_on_o}, 4'h0);
        stop_test();
    end
endmodule : testbench
`default_nettype wire
